// [capc_pkg.sv]
// Constants shared by the command/address parity checker and its error log.
// Assumes a 250 MHz command clock and a full-rate (1N) command bus.
package capc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;                 // Command clock period, 4 ns.
    localparam int ERROR_FLAG_ASSERT_DELAY_PS = 6000;    // Extra alert delay beyond the latency, 6 ns.
    localparam int ERROR_FLAG_PULSE_WIDTH_PS = 64000;    // Alert low time, plain default.
    // Longest times round down, never below one cycle.
    localparam int ON_CYC_RAW = ERROR_FLAG_ASSERT_DELAY_PS / CLK_PERIOD_PS;
    localparam int ON_CYC = (ON_CYC_RAW < 1) ? 1 : ON_CYC_RAW;
    localparam int PW_CYC_RAW = ERROR_FLAG_PULSE_WIDTH_PS / CLK_PERIOD_PS;
    localparam int PW_CYC = (PW_CYC_RAW < 1) ? 1 : PW_CYC_RAW;

    // ------------------------------------------------------------
    // Mode-register numbers and fields
    // ------------------------------------------------------------
    localparam logic [2:0] MR_READOUT = 3'h3;   // Holds the log readout enable.
    localparam logic [2:0] MR_PARITY = 3'h5;    // Holds latency, status and persistent mode.
    localparam int LAT_LSB = 0;                 // Parity latency field [2:0].
    localparam int STATUS_BIT = 4;              // Parity error status bit.
    localparam int PERSIST_BIT = 9;             // Persistent error mode bit.
    localparam int READOUT_BIT = 2;             // Log readout enable bit.

    // Parity latency codes and their clock counts.
    localparam logic [2:0] LAT_OFF = 3'h0;
    localparam logic [2:0] LAT_4 = 3'h1;
    localparam logic [2:0] LAT_5 = 3'h2;
    localparam logic [2:0] LAT_6 = 3'h3;
    localparam logic [2:0] LAT_8 = 3'h4;
    localparam logic [7:0] CLK_4 = 8'h04;
    localparam logic [7:0] CLK_5 = 8'h05;
    localparam logic [7:0] CLK_6 = 8'h06;
    localparam logic [7:0] CLK_8 = 8'h08;

    // ------------------------------------------------------------
    // Error log locations (byte wide, read only)
    // ------------------------------------------------------------
    localparam logic [1:0] PARITY_LOG_ADDR_LOW = 2'h0;
    localparam logic [1:0] PARITY_LOG_ADDR_HIGH = 2'h1;
    localparam logic [1:0] PARITY_LOG_COMMAND_BANK = 2'h2;
    localparam logic [1:0] PARITY_LOG_STATUS_LATENCY = 2'h3;
    localparam logic [7:0] LOG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Synchronised pin vector layout and reset value
    // ------------------------------------------------------------
    localparam int PIN_W = 30;
    localparam logic [29:0] PIN_RESET = 30'h20000000;    // Chip select idles high.

    // Alert sequencer states.
    typedef enum logic [1:0] {
        CAPC_IDLE = 2'b00,
        CAPC_WAIT = 2'b01,
        CAPC_ALERT = 2'b10
    } capc_state_type;

endpackage

// [capc_log_mem.sv]
// Four-byte error log with a registered read port.
// Assumes writer and reader share the command clock.
`timescale 1ns/1ps
module capc_log_mem
    import capc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [31:0] wr_frame,
    input wire logic rd_en,
    input wire logic [1:0] rd_index,
    output logic [7:0] rd_data_q
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem_q [4];    // One byte per log location.

    // The whole frame is captured at once so the four bytes always agree.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                mem_q[i] <= LOG_RESET;
            end
        end else if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                mem_q[i] <= wr_frame[8*i +: 8];
            end
        end
    end

    // Read data come from a register, one cycle after the request.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= LOG_RESET;
        end else if (rd_en) begin
            rd_data_q <= mem_q[rd_index];
        end
    end

endmodule // capc_log_mem

// [capc_checker.sv]
// Command/address parity checker of the memory device.
// Assumes all command pins arrive from outside and are synchronised here.
// What this block does
// - Normal mode: precharge, suspend checking until cleared.
// - Persistent mode: resume checking after alert pulse.
// - Erroneous self-refresh entry becomes precharge power-down.
// - Enabling mode write is never checked.
// - Disabling mode write is still checked.
// - Alert within latency clocks plus 6 ns for latency codes 4, 5, 6 and 8.
// - Log readable only when readout enable set.
// - Even parity over covered inputs and parity.
// - On error ignore, log, flag, drive alert.
// - Latency codes: off, 4, 5, 6, 8 clocks.
`timescale 1ns/1ps
module capc_checker
    import capc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic cke,
    input wire logic [17:0] addr,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic par,
    input wire logic [2:0] chip_id,
    input wire logic crc_error,
    output logic alert_n_q,
    output logic error_status_q,
    output logic exec_valid_q,
    output logic precharge_all_q,
    output logic selfrefresh_q,
    output logic powerdown_q,
    output logic log_valid_q,
    output logic [7:0] log_data_q
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pins_s1_q;    // First stage, read only by the second.
    logic [PIN_W-1:0] pins_q;       // Second stage, safe for logic.

    // Two flops before any logic sees a pin.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pins_s1_q <= PIN_RESET;
            pins_q <= PIN_RESET;
        end else begin
            pins_s1_q <= {cs_n, act_n, cke, addr, bg, ba, par, chip_id, crc_error};
            pins_q <= pins_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    wire s_cs_n = pins_q[29];
    wire s_act_n = pins_q[28];
    wire s_cke = pins_q[27];
    wire [17:0] s_addr = pins_q[26:9];
    wire [1:0] s_bg = pins_q[8:7];
    wire [1:0] s_ba = pins_q[6:5];
    wire s_par = pins_q[4];
    wire [2:0] s_cid = pins_q[3:1];
    wire s_crc = pins_q[0];
    wire ras_n = s_addr[16];
    wire cas_n = s_addr[15];
    wire we_n = s_addr[14];
    wire frame = !s_cs_n;
    wire is_mrs = frame && s_act_n && !ras_n && !cas_n && !we_n;
    wire is_ref = frame && s_act_n && !ras_n && !cas_n && we_n;
    wire is_rd = frame && s_act_n && ras_n && !cas_n && we_n;
    wire [2:0] mr_sel = {s_bg[0], s_ba};
    // Covered bits plus parity must hold an even count of ones.
    wire par_odd = ^{s_act_n, s_addr, s_bg, s_ba, s_par};

    // ------------------------------------------------------------
    // Mode state and alert sequencer
    // ------------------------------------------------------------
    capc_state_type state_q, state_d;    // Alert sequencer.
    logic [7:0] cnt_q, cnt_d;            // Cycles left in the current phase.
    logic [2:0] lat_q;                   // Parity latency code.
    logic persist_q;                     // Persistent error mode.
    logic readout_q;                     // Log readout enable.
    logic [7:0] pl_clocks;               // Latency in clocks.

    // Latency code to clock count; unlisted codes give zero clocks yet still enable checking.
    always_comb begin
        case (lat_q)
            LAT_4: pl_clocks = CLK_4;
            LAT_5: pl_clocks = CLK_5;
            LAT_6: pl_clocks = CLK_6;
            LAT_8: pl_clocks = CLK_8;
            default: pl_clocks = 8'h00;
        endcase
    end

    // Checking uses the latency held before this frame, so the write that
    // enables the mode passes unchecked and the one that disables it is checked.
    wire check_on = (lat_q != LAT_OFF) && (state_q == CAPC_IDLE)
        && (persist_q || !error_status_q);
    wire par_err = frame && check_on && par_odd;
    wire good = frame && !par_err && (state_q == CAPC_IDLE);
    wire mr5_wr = good && is_mrs && (mr_sel == MR_PARITY);
    wire mr3_wr = good && is_mrs && (mr_sel == MR_READOUT);
    // Writing a one to the status bit is blocked; only a zero clears it.
    wire status_clr = mr5_wr && !s_addr[STATUS_BIT];
    wire log_we = par_err && !error_status_q;
    wire log_rd = good && is_rd && readout_q;
    wire [7:0] on_total = pl_clocks + 8'(ON_CYC);

    // Next state of the alert sequencer.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            CAPC_IDLE: begin
                if (par_err) begin
                    state_d = CAPC_WAIT;
                    // Two synchroniser stages and the state register already
                    // spend three cycles, so the wait is shortened to keep the
                    // alert within latency plus on-delay from the pin edge.
                    cnt_d = on_total - 8'h03;
                end
            end
            CAPC_WAIT: begin
                if (cnt_q == 8'h00) begin
                    state_d = CAPC_ALERT;
                    cnt_d = 8'(PW_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            CAPC_ALERT: begin
                // Leaving here re-arms checking in persistent mode.
                if (cnt_q == 8'h00) begin
                    state_d = CAPC_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = CAPC_IDLE;
                cnt_d = 8'h00;
            end
        endcase
    end

    // Sequencer registers and alert pin; alert is low only in the pulse phase.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CAPC_IDLE;
            cnt_q <= 8'h00;
            alert_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            alert_n_q <= (state_d != CAPC_ALERT);
        end
    end

    // Mode register fields written by good mode writes.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lat_q <= LAT_OFF;
            persist_q <= 1'b0;
            readout_q <= 1'b0;
        end else begin
            if (mr5_wr) begin
                lat_q <= s_addr[LAT_LSB +: 3];
                persist_q <= s_addr[PERSIST_BIT];
            end
            if (mr3_wr) begin
                readout_q <= s_addr[READOUT_BIT];
            end
        end
    end

    // Status flag; a new error wins over a clear in the same cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            error_status_q <= 1'b0;
        end else if (par_err) begin
            error_status_q <= 1'b1;
        end else if (status_clr) begin
            error_status_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command effects towards the core
    // ------------------------------------------------------------
    // Erroneous frames are dropped; a precharge-all pulse closes banks after
    // the queues drain, which the core does on the same pulse.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            exec_valid_q <= 1'b0;
            precharge_all_q <= 1'b0;
        end else begin
            exec_valid_q <= good;
            precharge_all_q <= par_err;
        end
    end

    // Self-refresh entry: a bad entry frame lands in precharge power-down.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            selfrefresh_q <= 1'b0;
            powerdown_q <= 1'b0;
        end else if (s_cke) begin
            selfrefresh_q <= 1'b0;
            powerdown_q <= 1'b0;
        end else if (frame && is_ref && par_err) begin
            powerdown_q <= 1'b1;
        end else if (good && is_ref) begin
            selfrefresh_q <= 1'b1;
        end
    end

    // Read valid lines up with the registered log byte.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            log_valid_q <= 1'b0;
        end else begin
            log_valid_q <= log_rd;
        end
    end

    // ------------------------------------------------------------
    // Error log
    // ------------------------------------------------------------
    // Only the first error is kept until status clears.
    wire [31:0] log_frame = {s_crc, 1'b1, lat_q, s_cid,
        s_par, s_act_n, s_bg, s_ba, s_addr[17], s_addr[16],
        s_addr[15:8], s_addr[7:0]};

    capc_log_mem u_log (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(log_we),
        .wr_frame(log_frame),
        .rd_en(log_rd),
        .rd_index(s_ba),
        .rd_data_q(log_data_q)
    );

endmodule // capc_checker

// [capc_assertions.sv]
// Concurrent checks on the outputs of the command/address parity checker.
// Assumes one command clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module capc_assertions
    import capc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic alert_n_q,
    input wire logic error_status_q,
    input wire logic exec_valid_q,
    input wire logic precharge_all_q,
    input wire logic selfrefresh_q,
    input wire logic log_valid_q
);
    // ------------------------------------------------------------
    // Alert low-time counter
    // ------------------------------------------------------------
    logic [7:0] low_cnt_q; // Cycles the alert has been low so far.

    // Counts low cycles so that the full pulse width can be judged.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_q <= 8'h00;
        end else if (!alert_n_q) begin
            low_cnt_q <= low_cnt_q + 8'h01;
        end else begin
            low_cnt_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_alert_after_error: assert property (precharge_all_q |-> ##[3:7] !alert_n_q)
        else $error("alert late after parity error");
    a_alert_pulse_width: assert property ($rose(alert_n_q) |-> low_cnt_q == 8'(PW_CYC))
        else $error("alert pulse width wrong");
    a_error_no_exec: assert property (precharge_all_q |-> !exec_valid_q)
        else $error("erroneous frame executed");
    a_status_with_error: assert property (precharge_all_q |-> error_status_q)
        else $error("status not set on error");
    a_status_rise_cause: assert property ($rose(error_status_q) |-> precharge_all_q)
        else $error("status set without error");
    a_quiet_in_alert: assert property (!alert_n_q |-> !exec_valid_q && !precharge_all_q)
        else $error("frame acted on during alert");
    a_sre_blocked: assert property (precharge_all_q |-> !$rose(selfrefresh_q))
        else $error("self refresh entered on error");
    a_alert_needs_status: assert property (!alert_n_q |-> error_status_q)
        else $error("alert without status");

    cover property (precharge_all_q);
    cover property ($rose(alert_n_q));
    cover property (log_valid_q);
endmodule // capc_assertions

bind capc_checker capc_assertions u_capc_assertions (.mclk(mclk), .nrst(nrst), .alert_n_q(alert_n_q),
    .error_status_q(error_status_q), .exec_valid_q(exec_valid_q), .precharge_all_q(precharge_all_q),
    .selfrefresh_q(selfrefresh_q), .log_valid_q(log_valid_q));

// [capc_host_model.sv]
// Memory controller model that drives one command frame at a time.
// Assumes the testbench spaces frames and owns the clock.
`timescale 1ns/1ps
module capc_host_model (
    input wire logic mclk,
    output logic cs_n,
    output logic act_n,
    output logic cke,
    output logic [17:0] addr,
    output logic [1:0] bg,
    output logic [1:0] ba,
    output logic par
);
    // Idle bus with chip select released.
    initial begin
        cs_n = 1'b1;
        act_n = 1'b1;
        cke = 1'b1;
        addr = 18'h00000;
        bg = 2'h0;
        ba = 2'h0;
        par = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame, then deselect
    // ------------------------------------------------------------
    // Mode writes only ever carry a zero status bit and an even-safe code.
    // No half-rate switch or self-refresh exit traffic is issued.
    // Log bits for A17 and chip ID are really used by this device.
    task automatic send(input logic a, input logic k, input logic [17:0] ad, input logic [1:0] g,
                        input logic [1:0] b, input logic bad);
        @(posedge mclk);
        #1;
        cs_n = 1'b0;
        act_n = a;
        cke = k;
        addr = ad;
        bg = g;
        ba = b;
        par = (^{a, ad, g, b}) ^ bad;
        @(posedge mclk);
        #1;
        // Deselect with act_n, address, bank and parity inverted; the clock keeps running after every frame.
        cs_n = 1'b1;
        act_n = ~act_n;
        addr = ~addr;
        bg = ~bg;
        ba = ~ba;
        par = ~par;
    endtask
endmodule // capc_host_model

// [tb_ca_parity_checker.sv]
// Self-checking bench for the command/address parity checker.
// Assumes the checker and host model files are compiled before it.
`timescale 1ns/1ps
module tb_ca_parity_checker
    import capc_pkg::*;
;
    typedef struct packed {
        logic act_n;
        logic [17:0] addr;
        logic [1:0] bg;
        logic [1:0] ba;
        logic bad;
        logic ex;
        logic er;
    } capc_row_type;

    logic mclk, nrst, cs_n, act_n, cke, par, crc_error;
    logic [17:0] addr;
    logic [1:0] bg, ba;
    logic [2:0] chip_id;
    logic alert_n_q, error_status_q, exec_valid_q, precharge_all_q, selfrefresh_q, powerdown_q, log_valid_q;
    logic [7:0] log_data_q;
    logic ex, pr, lv, al7, al8, pd, sr; // Sampled responses of the last frame.
    logic [7:0] ld;
    logic [7:0] logb [4]; // Expected log bytes.
    capc_row_type rows [12];
    int bad_count, n_checks;

    capc_checker u_capc_checker (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .act_n(act_n), .cke(cke),
        .addr(addr), .bg(bg), .ba(ba), .par(par), .chip_id(chip_id), .crc_error(crc_error),
        .alert_n_q(alert_n_q), .error_status_q(error_status_q), .exec_valid_q(exec_valid_q),
        .precharge_all_q(precharge_all_q), .selfrefresh_q(selfrefresh_q), .powerdown_q(powerdown_q),
        .log_valid_q(log_valid_q), .log_data_q(log_data_q));
    capc_host_model u_capc_host_model (.mclk(mclk), .cs_n(cs_n), .act_n(act_n), .cke(cke), .addr(addr),
        .bg(bg), .ba(ba), .par(par));

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        test_done();
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Holds reset for 16 cycles and checks the idle outputs meanwhile.
    task automatic do_reset;
        nrst = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        chk("alert_n_q", alert_n_q, 8'h01);
        chk("outputs", {error_status_q, exec_valid_q, precharge_all_q, powerdown_q, selfrefresh_q, log_valid_q},
            8'h00);
        chk("log_data_q", log_data_q, 8'h00);
        nrst = 1'b1;
    endtask

    // Sends a frame and samples the answers at the fixed edges of the hand-over timing.
    task automatic do_frame(input logic a, input logic k, input logic [17:0] ad, input logic [1:0] g,
                            input logic [1:0] b, input logic bad);
        u_capc_host_model.send(a, k, ad, g, b, bad);
        repeat (2) @(posedge mclk);
        #1;
        ex = exec_valid_q;
        pr = precharge_all_q;
        lv = log_valid_q;
        ld = log_data_q;
        repeat (2) @(posedge mclk);
        #1;
        al7 = alert_n_q;
        @(posedge mclk);
        #1;
        al8 = alert_n_q;
        pd = powerdown_q;
        sr = selfrefresh_q;
        // Long gap covers mode delay plus latency and the whole alert.
        repeat (30) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_checks = 0;
        crc_error = 1'b1;
        chip_id = 3'h5;
        rows = '{{1'b0, 18'h1a5c3, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0}, {1'b1, 18'h00001, 2'h1, 2'h1, 1'b1, 1'b1, 1'b0},
                 {1'b0, 18'h0f0f0, 2'h2, 2'h3, 1'b0, 1'b1, 1'b0}, {1'b0, 18'h2a5c3, 2'h1, 2'h2, 1'b1, 1'b0, 1'b1},
                 {1'b0, 18'h12345, 2'h0, 2'h1, 1'b1, 1'b1, 1'b0}, {1'b1, 18'h00201, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0},
                 {1'b0, 18'h3ffff, 2'h3, 2'h3, 1'b1, 1'b0, 1'b1}, {1'b0, 18'h00000, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1},
                 {1'b1, 18'h00001, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0}, {1'b1, 18'h00000, 2'h1, 2'h1, 1'b1, 1'b0, 1'b1},
                 {1'b1, 18'h00000, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0}, {1'b0, 18'h1a5c3, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0}};
        do_reset();
        foreach (rows[i]) begin
            do_frame(rows[i].act_n, 1'b1, rows[i].addr, rows[i].bg, rows[i].ba, rows[i].bad);
            chk("exec_valid_q", ex, rows[i].ex);
            chk("precharge_all_q", pr, rows[i].er);
            chk("alert_n_q", {al7, al8}, {1'b1, ~rows[i].er});
        end
        // A mode write sets latency 4 again and clears the status.
        do_frame(1'b1, 1'b1, 18'h00001, 2'h1, 2'h1, 1'b0);
        // A frame right behind an error falls in the wait phase before the alert and is dropped.
        u_capc_host_model.send(1'b0, 1'b1, 18'h0f0f0, 2'h2, 2'h3, 1'b1);
        u_capc_host_model.send(1'b0, 1'b1, 18'h0f0f0, 2'h2, 2'h3, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk("exec_valid_q", exec_valid_q, 8'h00);
        repeat (30) @(posedge mclk);
        #1;
        // Clearing the status again lets the next error be logged.
        do_frame(1'b1, 1'b1, 18'h00001, 2'h1, 2'h1, 1'b0);
        do_frame(1'b1, 1'b0, 18'h27ca5, 2'h2, 2'h1, 1'b1);
        chk("sre_error", {pr, pd, sr}, 8'h06);
        // The log stays hidden until the readout enable is set.
        do_frame(1'b1, 1'b1, 18'h14000, 2'h0, 2'h0, 1'b0);
        chk("log_valid_q", lv, 8'h00);
        do_frame(1'b1, 1'b1, 18'h00004, 2'h0, 2'h3, 1'b0);
        logb[0] = 8'ha5;
        logb[1] = 8'h7c;
        logb[2] = {~(^{1'b1, 18'h27ca5, 2'h2, 2'h1}), 1'b1, 2'h2, 2'h1, 2'b10};
        logb[3] = {1'b1, 1'b1, LAT_4, 3'h5};
        for (int n = 0; n < 4; n++) begin
            do_frame(1'b1, 1'b1, 18'h14000, 2'h0, 2'(n), 1'b0);
            chk("log_valid_q", lv, 8'h01);
            chk("log_data_q", ld, logb[n]);
        end
        // A clean entry frame with clock enable low does enter self-refresh.
        do_frame(1'b1, 1'b0, 18'h04000, 2'h0, 2'h0, 1'b0);
        chk("sre_good", {pr, pd, sr}, 8'h01);
        do_reset();
        // Latency is off again after reset, so a bad frame still executes.
        do_frame(1'b0, 1'b1, 18'h1a5c3, 2'h0, 2'h0, 1'b1);
        chk("exec_valid_q", ex, 8'h01);
        test_done();
    end
endmodule // tb_ca_parity_checker
